// ===== verilog/asc_pkg.sv
// Shared constants for the actuator and spindle control register bank
package asc_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_SYS_CTRL = 8'h9E;
  localparam logic [7:0] ADDR_TEST_CTRL = 8'hAE;
  localparam logic [7:0] ADDR_ACT_CTRL = 8'hBE;
  localparam logic [7:0] ADDR_REV_IDENT = 8'hFF;

  // System control field positions
  localparam int SYS_PARK_A_BIT = 0;
  localparam int SYS_PARK_B_BIT = 1;
  localparam int SYS_CALIB_BIT = 2;
  localparam int SYS_RT_A_BIT = 3;
  localparam int SYS_RT_B_BIT = 4;
  localparam int SYS_RETRACT_BIT = 5;
  localparam int SYS_DOUBLE_BIT = 6;
  localparam int SYS_ENABLE_BIT = 7;

  // Test control field positions
  localparam int TST_MONITOR_BIT = 4;
  localparam int TST_BRAKE_BIT = 5;
  localparam int TST_BOOST_DIS_BIT = 7;

  // Actuator control field positions
  localparam int ACT_CHOP_SLEW_BIT = 0;
  localparam int ACT_FORCE_HIGH_BIT = 1;
  localparam int ACT_SLEEP_BIT = 2;
  localparam int ACT_COMM_SLEW_BIT = 3;

  // Parking levels in millivolts, indexed by {sel_a, sel_b}
  localparam logic [10:0] PARK_MV_00 = 11'h2D5;
  localparam logic [10:0] PARK_MV_01 = 11'h213;
  localparam logic [10:0] PARK_MV_10 = 11'h18E;
  localparam logic [10:0] PARK_MV_11 = 11'h438;

  // Retract durations in milliseconds
  localparam int RETRACT_MS_SHORT = 160;
  localparam int RETRACT_MS_MID = 320;
  localparam int RETRACT_MS_LONG = 640;

  // Clock rate and derived cycle counts
  localparam int CLK_KHZ = 250000;
  localparam int RETRACT_CYC_SHORT = RETRACT_MS_SHORT * CLK_KHZ;
  localparam int RETRACT_CYC_MID = RETRACT_MS_MID * CLK_KHZ;
  localparam int RETRACT_CYC_LONG = RETRACT_MS_LONG * CLK_KHZ;

  // Value after reset of every control field
  localparam logic [7:0] CTRL_RESET = 8'h00;
endpackage

// ===== verilog/asc_regs.sv
// Actuator and spindle control register bank with retract timer
`timescale 1ns/10ps
// What this block does
// - The three control registers take writes but always read back zero.
// - The two park select bits pick 0.725, 0.531, 0.398 or 1.080 volts.
// - The retract time bits pick 320, 640, 160 or 320 ms; retract starts it.
// - The calibration bit connects the internal 2 V reference.
// - The doubling bit doubles the spindle align and energize times.
// - The enable bit switches the actuator section on or off.
// - Monitor select routes speed when one and zero crossing when zero.
// - The brake bit commands reverse brake and must clear before start-up.
// - Chop slew select gives 10 V/us at zero and 20 V/us at one.
// - Force-high drives both actuator outputs high in phase-shift mode.
// - Commutation slew select gives 30 V/us at zero and 2 V/us at one.
// - The sleep bit of the actuator register has no effect.
// - Address FFh reads the revision code and ignores writes.
module asc_regs #(
  parameter logic [7:0] REV_CODE = 8'h5A, // Arbitrary revision value
  parameter int RETRACT_SHORT_CYCLES = asc_pkg::RETRACT_CYC_SHORT,
  parameter int RETRACT_MID_CYCLES = asc_pkg::RETRACT_CYC_MID,
  parameter int RETRACT_LONG_CYCLES = asc_pkg::RETRACT_CYC_LONG
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic phase_shift_modulation_i,
  input wire logic spindle_speed_i,
  input wire logic spindle_zero_cross_i,
  output logic [1:0] park_level_sel_o,
  output logic [10:0] park_level_mv_o,
  output logic [1:0] retract_duration_sel_o,
  output logic retract_active_o,
  output logic calib_reference_connect_o,
  output logic startup_timing_double_o,
  output logic actuator_enable_o,
  output logic monitor_output_select_o,
  output logic spindle_monitor_pin_o,
  output logic spindle_reverse_brake_o,
  output logic spindle_start_permit_o,
  output logic boost_disable_o,
  output logic actuator_chop_slew_sel_o,
  output logic actuator_outputs_force_high_o,
  output logic commutation_slew_sel_o
);

  logic wr_sys;
  logic wr_tst;
  logic wr_act;
  logic [1:0] park_next;
  logic [1:0] rt_next;
  logic retract_cmd_reg;
  logic retract_start;
  logic [31:0] retract_len;
  logic [31:0] retract_cnt_reg;
  logic retract_active_reg;
  logic [10:0] park_mv_next;
  logic force_high_bit_reg;

  // Write decode per register
  assign wr_sys = wr_i && (addr_i == asc_pkg::ADDR_SYS_CTRL);
  assign wr_tst = wr_i && (addr_i == asc_pkg::ADDR_TEST_CTRL);
  assign wr_act = wr_i && (addr_i == asc_pkg::ADDR_ACT_CTRL);

  // Field extraction from the system control write data
  assign park_next = {wdata_i[asc_pkg::SYS_PARK_A_BIT],
                      wdata_i[asc_pkg::SYS_PARK_B_BIT]};
  assign rt_next = {wdata_i[asc_pkg::SYS_RT_A_BIT],
                    wdata_i[asc_pkg::SYS_RT_B_BIT]};

  // Read port: only the identity register returns data
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i && addr_i == asc_pkg::ADDR_REV_IDENT) begin
      rdata_o <= REV_CODE;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Parking level lookup in millivolts
  always_comb begin
    unique case (park_next)
      2'b00: park_mv_next = asc_pkg::PARK_MV_00;
      2'b01: park_mv_next = asc_pkg::PARK_MV_01;
      2'b10: park_mv_next = asc_pkg::PARK_MV_10;
      2'b11: park_mv_next = asc_pkg::PARK_MV_11;
    endcase
  end

  // System control fields
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      park_level_sel_o <= 2'b00;
      park_level_mv_o <= asc_pkg::PARK_MV_00;
      retract_duration_sel_o <= 2'b00;
      retract_cmd_reg <= 1'b0;
      calib_reference_connect_o <= 1'b0;
      startup_timing_double_o <= 1'b0;
      actuator_enable_o <= 1'b0;
    end else if (wr_sys) begin
      park_level_sel_o <= park_next;
      park_level_mv_o <= park_mv_next;
      retract_duration_sel_o <= rt_next;
      retract_cmd_reg <= wdata_i[asc_pkg::SYS_RETRACT_BIT];
      calib_reference_connect_o <= wdata_i[asc_pkg::SYS_CALIB_BIT];
      startup_timing_double_o <= wdata_i[asc_pkg::SYS_DOUBLE_BIT];
      actuator_enable_o <= wdata_i[asc_pkg::SYS_ENABLE_BIT];
    end
  end

  // Retract starts when the command bit is newly written to one
  assign retract_start = wr_sys && wdata_i[asc_pkg::SYS_RETRACT_BIT] &&
                         !retract_cmd_reg;

  // Retract length chosen from the select bits being written
  always_comb begin
    unique case (rt_next)
      2'b00: retract_len = RETRACT_MID_CYCLES;
      2'b01: retract_len = RETRACT_LONG_CYCLES;
      2'b10: retract_len = RETRACT_SHORT_CYCLES;
      2'b11: retract_len = RETRACT_MID_CYCLES;
    endcase
  end

  // Retract timer: active for exactly the selected number of cycles
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      retract_cnt_reg <= 32'h0000_0000;
      retract_active_reg <= 1'b0;
    end else if (retract_start) begin
      retract_cnt_reg <= retract_len - 32'h0000_0001;
      retract_active_reg <= 1'b1;
    end else if (retract_active_reg) begin
      if (retract_cnt_reg == 32'h0000_0000) begin
        retract_active_reg <= 1'b0;
      end else begin
        retract_cnt_reg <= retract_cnt_reg - 32'h0000_0001;
      end
    end
  end

  assign retract_active_o = retract_active_reg;

  // Test control fields; unused bits are not stored
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      monitor_output_select_o <= 1'b0;
      spindle_reverse_brake_o <= 1'b0;
      spindle_start_permit_o <= 1'b1;
      boost_disable_o <= 1'b0;
    end else if (wr_tst) begin
      monitor_output_select_o <= wdata_i[asc_pkg::TST_MONITOR_BIT];
      spindle_reverse_brake_o <= wdata_i[asc_pkg::TST_BRAKE_BIT];
      spindle_start_permit_o <= !wdata_i[asc_pkg::TST_BRAKE_BIT];
      boost_disable_o <= wdata_i[asc_pkg::TST_BOOST_DIS_BIT];
    end
  end

  // Monitor pin mux, registered
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      spindle_monitor_pin_o <= 1'b0;
    end else if (monitor_output_select_o) begin
      spindle_monitor_pin_o <= spindle_speed_i;
    end else begin
      spindle_monitor_pin_o <= spindle_zero_cross_i;
    end
  end

  // Actuator control fields; sleep and unused bits are dropped
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      actuator_chop_slew_sel_o <= 1'b0;
      force_high_bit_reg <= 1'b0;
      commutation_slew_sel_o <= 1'b0;
    end else if (wr_act) begin
      actuator_chop_slew_sel_o <= wdata_i[asc_pkg::ACT_CHOP_SLEW_BIT];
      force_high_bit_reg <= wdata_i[asc_pkg::ACT_FORCE_HIGH_BIT];
      commutation_slew_sel_o <= wdata_i[asc_pkg::ACT_COMM_SLEW_BIT];
    end
  end

  // Force-high only takes effect in phase-shift modulation mode
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      actuator_outputs_force_high_o <= 1'b0;
    end else begin
      actuator_outputs_force_high_o <= force_high_bit_reg &&
                                       phase_shift_modulation_i;
    end
  end

  // Reads of write-only or unmapped addresses return zero
  chk_read_zero_wo: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (rd_i && addr_i != asc_pkg::ADDR_REV_IDENT) |=> (rdata_o == 8'h00))
    else $error("read of non-identity address returned data");

  // Identity read returns the revision code for one cycle only
  chk_ident_read_code: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (rd_i && addr_i == asc_pkg::ADDR_REV_IDENT) |=>
    (rdata_o == REV_CODE) ##1 (rdata_o == 8'h00 || $past(rd_i)))
    else $error("identity read data wrong");

  // Writing the identity address changes no control output
  chk_ident_write_none: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (wr_i && addr_i == asc_pkg::ADDR_REV_IDENT) |=>
    ($stable(park_level_sel_o) && $stable(actuator_enable_o) &&
     $stable(spindle_reverse_brake_o) && $stable(commutation_slew_sel_o)))
    else $error("identity write changed a control field");

  // Parking level follows its lookup table
  chk_park_level_map: assert property (
    @(posedge clock_i) disable iff (srst_i)
    wr_sys |=>
    (park_level_mv_o == ($past(park_next) == 2'b00 ? asc_pkg::PARK_MV_00 :
                         $past(park_next) == 2'b01 ? asc_pkg::PARK_MV_01 :
                         $past(park_next) == 2'b10 ? asc_pkg::PARK_MV_10 :
                         asc_pkg::PARK_MV_11)))
    else $error("parking level does not match select");

  // A fresh retract command raises retract active next cycle
  chk_retract_starts: assert property (
    @(posedge clock_i) disable iff (srst_i)
    retract_start |=> (retract_active_o &&
                       retract_cnt_reg == $past(retract_len) - 32'h1))
    else $error("retract did not start with the selected length");

  // Retract ends only when its count has run out
  chk_retract_ends: assert property (
    @(posedge clock_i) disable iff (srst_i)
    $fell(retract_active_o) |->
    ($past(retract_cnt_reg) == 32'h0000_0000 && !$past(retract_start)))
    else $error("retract ended before its duration");

  // Retract counter keeps moving while active
  chk_retract_counts: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (retract_active_o && !retract_start && retract_cnt_reg != 32'h0) |=>
    (retract_active_o && retract_cnt_reg == $past(retract_cnt_reg) - 32'h1))
    else $error("retract counter stalled");

  // System control enables follow the written bits
  chk_sys_bits_follow: assert property (
    @(posedge clock_i) disable iff (srst_i)
    wr_sys |=>
    (calib_reference_connect_o == $past(wdata_i[asc_pkg::SYS_CALIB_BIT]) &&
     startup_timing_double_o == $past(wdata_i[asc_pkg::SYS_DOUBLE_BIT]) &&
     actuator_enable_o == $past(wdata_i[asc_pkg::SYS_ENABLE_BIT])))
    else $error("system control field not taken");

  // Actuator enable holds between writes
  chk_enable_holds: assert property (
    @(posedge clock_i) disable iff (srst_i)
    !wr_sys |=> $stable(actuator_enable_o) && $stable(startup_timing_double_o))
    else $error("actuator enable changed without a write");

  // Monitor pin carries the selected spindle signal
  chk_monitor_mux: assert property (
    @(posedge clock_i) disable iff (srst_i)
    1'b1 |=> (spindle_monitor_pin_o == ($past(monitor_output_select_o) ?
              $past(spindle_speed_i) : $past(spindle_zero_cross_i))))
    else $error("monitor pin carries the wrong signal");

  // Start-up is permitted exactly when reverse brake is off
  chk_brake_permit: assert property (
    @(posedge clock_i) disable iff (srst_i)
    spindle_start_permit_o == !spindle_reverse_brake_o)
    else $error("start permit disagrees with reverse brake");

  // Force-high only in phase-shift modulation mode
  chk_force_high_psm: assert property (
    @(posedge clock_i) disable iff (srst_i)
    actuator_outputs_force_high_o |->
    ($past(phase_shift_modulation_i) && $past(force_high_bit_reg)))
    else $error("outputs forced high outside phase-shift mode");

  // Slew selects follow the actuator control write
  chk_slew_selects: assert property (
    @(posedge clock_i) disable iff (srst_i)
    wr_act |=>
    (actuator_chop_slew_sel_o == $past(wdata_i[asc_pkg::ACT_CHOP_SLEW_BIT]) &&
     commutation_slew_sel_o == $past(wdata_i[asc_pkg::ACT_COMM_SLEW_BIT])))
    else $error("slew select not taken");

  // Sleep and unused bits have no effect on any output
  chk_sleep_ignored: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (wr_act && (wdata_i & 8'h0B) == {4'h0, commutation_slew_sel_o, 1'b0,
                                     force_high_bit_reg,
                                     actuator_chop_slew_sel_o}) |=>
    ($stable(actuator_chop_slew_sel_o) && $stable(commutation_slew_sel_o) &&
     $stable(force_high_bit_reg)))
    else $error("ignored actuator bit changed state");

  // Retract time select follows the system control write
  chk_retract_sel_map: assert property (
    @(posedge clock_i) disable iff (srst_i)
    wr_sys |=>
    (retract_duration_sel_o == {$past(wdata_i[asc_pkg::SYS_RT_A_BIT]),
                                $past(wdata_i[asc_pkg::SYS_RT_B_BIT])}))
    else $error("retract time select not taken");

  // Test control fields follow the written bits
  chk_test_bits_follow: assert property (
    @(posedge clock_i) disable iff (srst_i)
    wr_tst |=>
    (monitor_output_select_o == $past(wdata_i[asc_pkg::TST_MONITOR_BIT]) &&
     spindle_reverse_brake_o == $past(wdata_i[asc_pkg::TST_BRAKE_BIT]) &&
     boost_disable_o == $past(wdata_i[asc_pkg::TST_BOOST_DIS_BIT])))
    else $error("test control field not taken");

  // Brake, monitor select and boost hold between writes
  chk_brake_holds: assert property (
    @(posedge clock_i) disable iff (srst_i)
    !wr_tst |=>
    ($stable(spindle_reverse_brake_o) && $stable(monitor_output_select_o) &&
     $stable(boost_disable_o)))
    else $error("test control field changed without a write");

  // Slew selects hold between actuator control writes
  chk_slew_holds: assert property (
    @(posedge clock_i) disable iff (srst_i)
    !wr_act |=>
    ($stable(actuator_chop_slew_sel_o) && $stable(commutation_slew_sel_o)))
    else $error("slew select changed without a write");

  // Stored force-high bit in phase-shift mode drives the outputs high
  chk_force_high_on: assert property (
    @(posedge clock_i) disable iff (srst_i)
    (force_high_bit_reg && phase_shift_modulation_i) |=>
    actuator_outputs_force_high_o)
    else $error("outputs not forced high in phase-shift mode");

  // Reset leaves the actuator off, no retract and start-up permitted
  chk_reset_clears: assert property (
    @(posedge clock_i)
    srst_i |=> (spindle_start_permit_o && !spindle_reverse_brake_o &&
                !actuator_enable_o && !retract_active_o && rdata_o == 8'h00))
    else $error("outputs not cleared by reset");

endmodule

// ===== sim/tb_top.sv
// Self-checking bench for the actuator and spindle control register bank
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] REV = 8'h3C; // Arbitrary revision value
  localparam int T_SHORT = 5;
  localparam int T_MID = 10;
  localparam int T_LONG = 20;
  localparam int LIMIT = 3000;
  localparam logic [7:0] ADDR_SPIN_LOOP = 8'h8E; // Outside this bank
  logic clock_i, srst_i, wr_i, rd_i, psm_i, speed_i, zero_i;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic [1:0] park_sel, rt_sel;
  logic [10:0] park_mv;
  logic retract, calib, dbl, act_en, mon_sel, mon_pin, brake, permit;
  logic boost_dis, chop, force_hi, comm;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0;
  logic [10:0] mv_tab [4] = '{11'h2D5, 11'h213, 11'h18E, 11'h438};
  int rt_tab [4] = '{T_MID, T_LONG, T_SHORT, T_MID};

  asc_regs #(.REV_CODE(REV), .RETRACT_SHORT_CYCLES(T_SHORT),
    .RETRACT_MID_CYCLES(T_MID), .RETRACT_LONG_CYCLES(T_LONG)) asc_regs_i (
    .clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .phase_shift_modulation_i(psm_i), .spindle_speed_i(speed_i),
    .spindle_zero_cross_i(zero_i), .park_level_sel_o(park_sel),
    .park_level_mv_o(park_mv), .retract_duration_sel_o(rt_sel),
    .retract_active_o(retract), .calib_reference_connect_o(calib),
    .startup_timing_double_o(dbl), .actuator_enable_o(act_en),
    .monitor_output_select_o(mon_sel), .spindle_monitor_pin_o(mon_pin),
    .spindle_reverse_brake_o(brake), .spindle_start_permit_o(permit),
    .boost_disable_o(boost_dis), .actuator_chop_slew_sel_o(chop),
    .actuator_outputs_force_high_o(force_hi),
    .commutation_slew_sel_o(comm));

  // Clock at 250 MHz
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // Cycle count and hang guard
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      report_and_stop();
    end
  end

  // Compare one value and count it
  task automatic check(input string nm, input logic [10:0] exp,
                       input logic [10:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
      err_count++;
    end
  endtask

  // One-cycle write; returns just after the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    #1;
  endtask

  // One-cycle read; data is looked at in the following cycle only
  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string nm);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    check(nm, {3'h0, exp}, {3'h0, rdata_o});
  endtask

  // Wait for a retract to end and check its length in cycles
  task automatic retract_len(input int exp);
    int k;
    k = 0;
    while (retract === 1'b1 && k < 100) begin
      @(posedge clock_i);
      #1;
      k++;
    end
    check("retract_len", exp[10:0], 11'(cyc - t0));
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    srst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    psm_i = 1'b0;
    speed_i = 1'b1;
    zero_i = 1'b0;
    repeat (20) @(posedge clock_i);
    srst_i <= 1'b0;
    #1;
    check("reset_mv", 11'h2D5, park_mv);
    check("reset_permit", 11'h001, {10'h0, permit});
    check("reset_en", 11'h000, {10'h0, act_en});
    $display("test reset done");
    // Parking codes, and the control registers never read back
    for (int i = 0; i < 4; i++) begin
      wr(asc_pkg::ADDR_SYS_CTRL, {6'h00, i[0], i[1]});
      check("park_sel", {9'h0, i[1:0]}, {9'h0, park_sel});
      check("park_mv", mv_tab[i], park_mv);
    end
    rd(asc_pkg::ADDR_SYS_CTRL, 8'h00, "rd_sys");
    wr(asc_pkg::ADDR_TEST_CTRL, 8'hB0);
    rd(asc_pkg::ADDR_TEST_CTRL, 8'h00, "rd_test");
    wr(asc_pkg::ADDR_ACT_CTRL, 8'h0B);
    rd(asc_pkg::ADDR_ACT_CTRL, 8'h00, "rd_act");
    $display("test park and write-only done");
    // Enable, doubling and reference connect
    wr(asc_pkg::ADDR_SYS_CTRL, 8'hC4);
    check("sys_bits", 11'h007, {8'h0, act_en, dbl, calib});
    wr(asc_pkg::ADDR_SYS_CTRL, 8'h00);
    check("sys_clear", 11'h000, {8'h0, act_en, dbl, calib});
    $display("test system fields done");
    // Retract length for each time code, with a rewrite that must not restart
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_SPIN_LOOP, 8'h00);
      wr(asc_pkg::ADDR_SYS_CTRL, {3'h1, i[0], i[1], 3'h0});
      t0 = cyc;
      check("rt_sel", {9'h0, i[1:0]}, {9'h0, rt_sel});
      if (i == 0) begin
        wr(asc_pkg::ADDR_SYS_CTRL, 8'h20);
      end
      retract_len(rt_tab[i]);
      wr(asc_pkg::ADDR_SYS_CTRL, 8'h00);
    end
    // Reset in mid retract stops it
    wr(asc_pkg::ADDR_SYS_CTRL, 8'hA0);
    check("rt_start", 11'h003, {9'h0, retract, act_en});
    @(posedge clock_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    #1;
    check("rt_reset", 11'h000, {9'h0, retract, act_en});
    $display("test retract done");
    // Monitor routing, reverse brake, boost disable
    wr(asc_pkg::ADDR_TEST_CTRL, 8'hB0);
    @(posedge clock_i);
    #1;
    check("tst_on", 11'h01B,
          {7'h0, mon_sel, brake, permit, boost_dis, mon_pin});
    wr(asc_pkg::ADDR_TEST_CTRL, 8'h00);
    @(posedge clock_i);
    #1;
    check("tst_off", 11'h004,
          {7'h0, mon_sel, brake, permit, boost_dis, mon_pin});
    @(posedge clock_i);
    speed_i <= 1'b0;
    zero_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    check("mon_zero", 11'h001, {10'h0, mon_pin});
    wr(asc_pkg::ADDR_TEST_CTRL, 8'h4F);
    check("tst_unused", 11'h004,
          {7'h0, mon_sel, brake, permit, boost_dis, 1'b0});
    $display("test test-control done");
    // Actuator control fields, force high only in phase-shift mode
    @(posedge clock_i);
    psm_i <= 1'b1;
    wr(asc_pkg::ADDR_ACT_CTRL, 8'h0B);
    @(posedge clock_i);
    #1;
    check("act_on", 11'h007,
          {8'h0, chop, force_hi, comm});
    // Setting only the sleep bit leaves every field as it was
    wr(asc_pkg::ADDR_ACT_CTRL, 8'h0F);
    check("act_sleep", 11'h007, {8'h0, chop, force_hi, comm});
    @(posedge clock_i);
    psm_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    check("force_nopsm", 11'h000, {10'h0, force_hi});
    wr(asc_pkg::ADDR_ACT_CTRL, 8'hF4);
    @(posedge clock_i);
    psm_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    check("act_unused", 11'h000, {8'h0, chop, force_hi, comm});
    $display("test actuator control done");
    // Identification register, writes to it and unmapped places
    rd(asc_pkg::ADDR_REV_IDENT, REV, "rev");
    wr(asc_pkg::ADDR_REV_IDENT, 8'h00);
    rd(asc_pkg::ADDR_REV_IDENT, REV, "rev_after_wr");
    rd(8'h10, 8'h00, "rd_unmapped");
    wr(8'h9F, 8'hFF);
    check("unmapped_wr", 11'h2D5, park_mv);
    $display("test identification done");
    report_and_stop();
  end
endmodule
